// File: multi_channel_sync_pwm_timer.sv
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - six channels run synchronously in PWM mode 2 to give up to twenty-three PWM phases.
// - channel 0 clears its counter on a match with its general register A, setting the cycle.
// - channels 1 to 5 can select synchronous clear, following any clearing group member.
// - the sync select register holds one bit per channel; 0x3f puts all six in the group.
// - the start register holds one run bit per channel; 0x06 runs channels 1 and 2 only.
// - writing 0xc3 to a channel mode register selects PWM mode 2.
// - writing 0xc2 to a channel mode register selects PWM mode 1.
// - in PWM mode 2 each non-cycle general register drives its pin high on a match.
// - in PWM mode 1 registers A/B and C/D pair, one setting the high point, one the low.
// - a channel can clear its counter on a falling edge captured on its trigger pin.
// - one clear in the group clears at once every synchronised counter set to synchronous clear.
// - trigger delay is at least 200 ns and width at least 50 ns within the trigger period.
// - one counter tick is the 50 ns base period times the channel's division ratio.
// - at the 20 MHz base rate PWM cycles from 100 ns to 3.27 ms are reachable.
// - in cascade, channel 1 counts channel 2 overflows to form a 32-bit counter.
module multi_channel_sync_pwm_timer (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [5:0] triggerCapturePin,
   output logic [23:0] pwmOutputPin
);
   localparam int NCH = timer_pkg::NUM_CH;

   // software visible state
   logic [5:0] counterStart;
   logic [5:0] syncSelect;
   logic moduleStop;
   logic [5:0] timingFault;
   logic [7:0] channelControl [NCH];
   logic [7:0] channelMode [NCH];
   logic [7:0] pinLevelControl [NCH];
   logic [15:0] generalReg [NCH][timer_pkg::NUM_GR];

   // channel status
   logic [15:0] channelCounter [NCH];
   logic [5:0] ownClear;
   logic [5:0] counterClear;
   logic [5:0] overflow;
   logic [5:0] captureHit;
   logic [5:0] tooSoon;
   logic [5:0] chTick;
   logic [3:0] ticks;
   logic syncClear;

   // write channel holding state
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic awHeld;
   logic wHeld;
   logic doWrite;
   logic wrMapped;
   logic [2:0] wrCh;
   logic [2:0] wrIdx;
   logic wrGlobal;

   // read decode
   logic [31:0] readData;
   logic readMapped;
   logic [2:0] rdCh;
   logic [2:0] rdIdx;

   // merge 16 bits of write data under the low two byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // write address acceptance, one write at a time
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         awready <= 1'b0;
         awHeld <= 1'b0;
         wrAddr <= 8'h00;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         awHeld <= 1'b1;
         wrAddr <= awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end else if (!awHeld && !bvalid) begin
         awready <= 1'b1;
      end
   end

   // write data acceptance, either order against the address
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wready <= 1'b0;
         wHeld <= 1'b0;
         wrData <= 32'h00000000;
         wrStrb <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         wHeld <= 1'b1;
         wrData <= wdata;
         wrStrb <= wstrb;
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end else if (!wHeld && !bvalid) begin
         wready <= 1'b1;
      end
   end

   // write decode
   assign doWrite = awHeld && wHeld && !bvalid;
   assign wrCh = wrAddr[7:5];
   assign wrIdx = wrAddr[4:2];
   assign wrGlobal = (wrCh == 3'h0) && !wrAddr[4];
   assign wrMapped = wrGlobal || (wrCh >= timer_pkg::CH_FIRST && wrCh <= timer_pkg::CH_LAST);

   // write response after both halves are in
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bvalid <= 1'b0;
         bresp <= timer_pkg::RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp <= wrMapped ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // start, sync select and module stop registers
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         counterStart <= timer_pkg::START_RST;
         syncSelect <= timer_pkg::SYNC_RST;
         moduleStop <= timer_pkg::STOP_RST;
      end else if (doWrite && wrGlobal && wrStrb[0]) begin
         if (wrAddr[3:2] == timer_pkg::OFS_START[3:2]) begin
            counterStart <= wrData[5:0];
         end else if (wrAddr[3:2] == timer_pkg::OFS_SYNC[3:2]) begin
            syncSelect <= wrData[5:0];
         end else if (wrAddr[3:2] == timer_pkg::OFS_STOP[3:2]) begin
            moduleStop <= wrData[0];
         end
      end
   end

   // trigger timing faults: write one to clear, a new fault wins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         timingFault <= 6'h00;
      end else if (doWrite && wrGlobal && wrStrb[0] &&
                   wrAddr[3:2] == timer_pkg::OFS_STATUS[3:2]) begin
         timingFault <= (timingFault & ~wrData[5:0]) | tooSoon;
      end else begin
         timingFault <= timingFault | tooSoon;
      end
   end

   // group clear from every synchronised channel's own clear
   assign syncClear = |(ownClear & syncSelect);

   // shared ratio prescaler, halted in module stop
   timer_prescaler u_prescaler (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .enable(!moduleStop),
      .ticks(ticks)
   );

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic run;
      logic hit;
      logic [2:0] cks;
      logic [2:0] clrSel;
      logic [3:0] mode;
      logic [3:0] match;
      logic [3:0] pins;

      assign run = counterStart[c] && !moduleStop;
      assign hit = doWrite && (wrCh == 3'(c + 1));
      assign cks = channelControl[c][timer_pkg::CKS_LSB +: 3];
      assign clrSel = channelControl[c][timer_pkg::CLR_LSB +: 3];
      assign mode = channelMode[c][3:0];

      // tick source: divided base clock or, for the upper half, low half overflow
      if (c == timer_pkg::CASCADE_HI_CH) begin : g_casc
         assign chTick[c] = run && ((cks == timer_pkg::CKS_CASCADE) ?
                            overflow[timer_pkg::CASCADE_LO_CH] : ticks[cks[1:0]]);
      end else begin : g_plain
         assign chTick[c] = run && ticks[cks[1:0]];
      end

      // compare matches against the four general registers
      for (genvar g = 0; g < timer_pkg::NUM_GR; g++) begin : g_cmp
         assign match[g] = chTick[c] && (channelCounter[c] == generalReg[c][g]);
      end

      // control, mode and pin level registers
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            channelControl[c] <= timer_pkg::CTRL_RST;
            channelMode[c] <= timer_pkg::MODE_RST;
            pinLevelControl[c] <= timer_pkg::PIN_RST;
         end else if (hit && wrStrb[0]) begin
            if (wrIdx == timer_pkg::IDX_CTRL) begin
               channelControl[c] <= wrData[7:0];
            end else if (wrIdx == timer_pkg::IDX_MODE) begin
               channelMode[c] <= wrData[7:0];
            end else if (wrIdx == timer_pkg::IDX_PIN) begin
               pinLevelControl[c] <= wrData[7:0];
            end
         end
      end

      // general registers; a capture into A beats a bus write
      for (genvar g = 0; g < timer_pkg::NUM_GR; g++) begin : g_gr
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               generalReg[c][g] <= timer_pkg::GR_RST;
            end else if (g == 0 && captureHit[c]) begin
               generalReg[c][g] <= channelCounter[c];
            end else if (hit && wrIdx == 3'(timer_pkg::IDX_GR_A + 3'(g))) begin
               generalReg[c][g] <= merge16(generalReg[c][g], wrData, wrStrb);
            end
         end
      end

      timer_channel u_channel (
         .clk_sys(clk_sys),
         .resetn(resetn),
         .run(run),
         .tick(chTick[c]),
         .clearSel(clrSel),
         .syncMember(syncSelect[c]),
         .syncClearIn(syncClear),
         .match(match),
         .captureEnable(pinLevelControl[c][timer_pkg::CAPA_FALL_BIT]),
         .triggerPin(triggerCapturePin[c]),
         .cntWrite(hit && wrIdx == timer_pkg::IDX_COUNT && wrStrb[1:0] != 2'b00),
         .cntData(merge16(channelCounter[c], wrData, wrStrb)),
         .count(channelCounter[c]),
         .ownClear(ownClear[c]),
         .counterClear(counterClear[c]),
         .overflow(overflow[c]),
         .captureHit(captureHit[c]),
         .tooSoon(tooSoon[c])
      );

      // pin waveforms per mode
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            pins <= 4'h0;
         end else if (mode == timer_pkg::MODE_PWM2) begin
            for (int g = 0; g < timer_pkg::NUM_GR; g++) begin
               // the cycle register's own pin stays low
               if (counterClear[c] || (g < 2 && clrSel == timer_pkg::CLR_A + 3'(g)) ||
                   (g >= 2 && clrSel == timer_pkg::CLR_C + 3'(g - 2))) begin
                  pins[g] <= 1'b0;
               end else if (match[g]) begin
                  pins[g] <= 1'b1;
               end
            end
         end else if (mode == timer_pkg::MODE_PWM1) begin
            // A raises and B drops the first pin, C and D the third
            if (match[1]) begin
               pins[0] <= 1'b0;
            end else if (match[0]) begin
               pins[0] <= 1'b1;
            end
            if (match[3]) begin
               pins[2] <= 1'b0;
            end else if (match[2]) begin
               pins[2] <= 1'b1;
            end
            pins[1] <= 1'b0;
            pins[3] <= 1'b0;
         end else begin
            pins <= 4'h0;
         end
      end

      assign pwmOutputPin[4*c +: 4] = pins;
   end

   // read decode
   assign rdCh = araddr[7:5];
   assign rdIdx = araddr[4:2];

   always_comb begin
      readData = 32'h00000000;
      readMapped = 1'b1;
      if (rdCh == 3'h0 && !araddr[4]) begin
         if (araddr[3:2] == timer_pkg::OFS_START[3:2]) begin
            readData = {26'h0, counterStart};
         end else if (araddr[3:2] == timer_pkg::OFS_SYNC[3:2]) begin
            readData = {26'h0, syncSelect};
         end else if (araddr[3:2] == timer_pkg::OFS_STOP[3:2]) begin
            readData = {31'h0, moduleStop};
         end else begin
            readData = {26'h0, timingFault};
         end
      end else if (rdCh >= timer_pkg::CH_FIRST && rdCh <= timer_pkg::CH_LAST) begin
         if (rdIdx == timer_pkg::IDX_CTRL) begin
            readData = {24'h0, channelControl[rdCh - 3'h1]};
         end else if (rdIdx == timer_pkg::IDX_MODE) begin
            readData = {24'h0, channelMode[rdCh - 3'h1]};
         end else if (rdIdx == timer_pkg::IDX_PIN) begin
            readData = {24'h0, pinLevelControl[rdCh - 3'h1]};
         end else if (rdIdx == timer_pkg::IDX_COUNT) begin
            readData = {16'h0, channelCounter[rdCh - 3'h1]};
         end else begin
            readData = {16'h0, generalReg[rdCh - 3'h1][rdIdx[1:0]]};
         end
      end else begin
         readMapped = 1'b0;
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= timer_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= readData;
         rresp <= readMapped ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else if (!rvalid) begin
         arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: multi_channel_sync_pwm_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module multi_channel_sync_pwm_timer_bench;
   logic clk_sys = 1'b0, resetn = 1'b0, trigOn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, seed = 32'ha1e9;
   logic [3:0] wstrb = 4'hf;
   wire logic awready, wready, bvalid, arready, rvalid;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [5:0] triggerCapturePin;
   wire logic [23:0] pwmOutputPin;
   int errors = 0, n_compared = 0, cyc = 0;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   localparam logic [1:0] ERR = timer_pkg::RESP_SLVERR;
   always #2.5 clk_sys = ~clk_sys;
   multi_channel_sync_pwm_timer multi_channel_sync_pwm_timer_inst (
      .clk_sys, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .triggerCapturePin, .pwmOutputPin
   );
   trigger_source #(.PERIOD(400), .LOW(20)) trigger_source_inst (
      .clk_sys, .enable(trigOn), .pin(triggerCapturePin)
   );
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // byte address of word i in channel c
   function automatic logic [7:0] ca(input int c, input int i);
      return 8'(32 * (c + 1) + 4 * i);
   endfunction
   task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      if (errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
      bq.push_back(r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
      rq.push_back({r, d});
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask
   task automatic waitpin(input int i, input logic v, output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pwmOutputPin[i] !== v && n < 3000);
   endtask
   // high time and period of one pin, skipping the first, possibly unaligned, cycle
   task automatic msr(input int i, input int hi, input int per);
      int n, h, l;
      waitpin(i, 1'b0, n);
      waitpin(i, 1'b1, n);
      waitpin(i, 1'b0, n);
      waitpin(i, 1'b1, n);
      waitpin(i, 1'b0, h);
      waitpin(i, 1'b1, l);
      if (hi > 0) chk("width", 34'(hi), 34'(h));
      chk("period", 34'(per), 34'(h + l));
   endtask
   // answers are matched against the oldest expectation
   always @(posedge clk_sys) begin
      if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
      if (bvalid && bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      int c;
      logic [15:0] v;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(timer_pkg::OFS_START, 32'h0);
      rd(timer_pkg::OFS_STOP, 32'h1);
      rd(ca(3, 1), 32'hc0);
      rd(ca(5, 4), 32'hffff);
      rd(8'h10, 32'h0, ERR);
      wr(8'h10, 32'h5a, ERR);
      wr(timer_pkg::OFS_STOP, 32'h0);
      wr(timer_pkg::OFS_SYNC, 32'h3f);
      rd(timer_pkg::OFS_SYNC, 32'h3f);
      wr(timer_pkg::OFS_START, 32'h06);
      rd(timer_pkg::OFS_START, 32'h06);
      rd(ca(0, 3), 32'h0);
      wr(timer_pkg::OFS_START, 32'h0);
      // random general registers, both modes, then mode 2 with sync clear
      for (c = 0; c < 6; c++) begin
         v = 16'(xs());
         wr(ca(c, 4 + c % 4), {16'h0, v});
         rd(ca(c, 4 + c % 4), {16'h0, v});
         wr(ca(c, 1), 32'hc2);
         rd(ca(c, 1), 32'hc2);
         wr(ca(c, 0), c == 0 ? 32'h20 : 32'h60);
         wr(ca(c, 1), 32'hc3);
      end
      wr(ca(0, 4), 32'h13);
      wr(ca(0, 5), 32'h5);
      wr(ca(1, 5), 32'h8);
      wr(timer_pkg::OFS_START, 32'h3f);
      msr(1, 0, 200);
      msr(5, 0, 200);
      chk("cycle pin", 34'h0, 34'(pwmOutputPin[0]));
      // mode 1 pulses on channel 2 timed from channel 1's trigger
      wr(timer_pkg::OFS_START, 32'h0);
      wr(ca(0, 0), 32'h60);
      wr(ca(1, 0), 32'h20);
      wr(ca(1, 2), 32'h1);
      wr(ca(2, 1), 32'hc2);
      wr(ca(2, 4), 32'h6);
      wr(ca(2, 5), 32'ha);
      trigOn <= 1'b1;
      wr(timer_pkg::OFS_START, 32'h3f);
      msr(8, 40, 400);
      conclude();
   end
endmodule
`default_nettype wire

// File: multi_channel_sync_pwm_timer_sva.sv
`timescale 1ns/10ps
`default_nettype none
module multi_channel_sync_pwm_timer_sva (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // address and data taken at one edge; readies come back two edges after the answer is taken
   sequence s_wtake;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_reopen;
      !awready ##1 (awready && wready);
   endsequence
   // bus answers, blocking and release
   property p_bans; s_wtake |-> ##2 bvalid; endproperty
   property p_rans; arvalid && arready |=> rvalid && !arready; endproperty
   property p_bdone; bvalid && bready |=> !bvalid; endproperty
   property p_rdone; rvalid && rready |=> !rvalid; endproperty
   property p_wblk; bvalid |-> !awready && !wready; endproperty
   property p_rblk; rvalid |-> !arready; endproperty
   property p_wrdy; bvalid && bready |=> s_reopen; endproperty
   property p_rrdy; rvalid && rready |=> !arready ##1 arready; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
   a_rans: assert property (p_rans) else $error("read answer late");
   a_bdone: assert property (p_bdone) else $error("write answer held");
   a_rdone: assert property (p_rdone) else $error("read answer held");
   a_wblk: assert property (p_wblk) else $error("write taken early");
   a_rblk: assert property (p_rblk) else $error("read taken early");
   a_wrdy: assert property (p_wrdy) else $error("write ready timing");
   a_rrdy: assert property (p_rrdy) else $error("read ready timing");
endmodule
bind multi_channel_sync_pwm_timer multi_channel_sync_pwm_timer_sva
   multi_channel_sync_pwm_timer_sva_inst (.clk_sys, .resetn, .awvalid, .awready, .wvalid,
   .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready);
`default_nettype wire

// File: timer_channel.sv
`timescale 1ns/10ps
`default_nettype none
module timer_channel (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic run,
   input wire logic tick,
   input wire logic [2:0] clearSel,
   input wire logic syncMember,
   input wire logic syncClearIn,
   input wire logic [3:0] match,
   input wire logic captureEnable,
   input wire logic triggerPin,
   input wire logic cntWrite,
   input wire logic [15:0] cntData,
   output logic [15:0] count,
   output logic ownClear,
   output logic counterClear,
   output logic overflow,
   output logic captureHit,
   output logic tooSoon
);
   logic pinPrev;

   // trigger pin history for falling edge detection
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pinPrev <= 1'b0;
      end else begin
         pinPrev <= triggerPin;
      end
   end

   assign captureHit = run && captureEnable && pinPrev && !triggerPin;

   // clear caused by this channel's own selected source
   always_comb begin
      case (clearSel)
         timer_pkg::CLR_A: ownClear = match[0] || captureHit;
         timer_pkg::CLR_B: ownClear = match[1];
         timer_pkg::CLR_C: ownClear = match[2];
         timer_pkg::CLR_D: ownClear = match[3];
         default: ownClear = 1'b0;
      endcase
   end

   // synchronous clear follows any clearing member of the group
   assign counterClear = (clearSel == timer_pkg::CLR_SYNC) ?
                         (syncMember && syncClearIn) : ownClear;
   assign overflow = tick && (count == timer_pkg::COUNT_MAX) && !counterClear;
   assign tooSoon = captureHit && (count < timer_pkg::MIN_TRIGGER_TICKS);

   // 16-bit up counter, wraps after its maximum
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         count <= 16'h0000;
      end else if (cntWrite) begin
         count <= cntData;
      end else if (counterClear) begin
         count <= 16'h0000;
      end else if (tick) begin
         count <= count + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// File: timer_pkg.sv
package timer_pkg;
   // channel and register counts
   localparam int NUM_CH = 6;
   localparam int NUM_GR = 4;
   localparam int ADDR_W = 8;

   // global register byte offsets
   localparam logic [7:0] OFS_START = 8'h00;
   localparam logic [7:0] OFS_SYNC = 8'h04;
   localparam logic [7:0] OFS_STOP = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   // channel c sits at (c + 1) * 0x20; word index inside the channel window
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_MODE = 3'h1;
   localparam logic [2:0] IDX_PIN = 3'h2;
   localparam logic [2:0] IDX_COUNT = 3'h3;
   localparam logic [2:0] IDX_GR_A = 3'h4;
   localparam logic [2:0] CH_FIRST = 3'h1;
   localparam logic [2:0] CH_LAST = 3'h6;

   // channel control register fields
   localparam int CKS_LSB = 0;
   localparam int CLR_LSB = 5;
   localparam logic [2:0] CKS_DIV1 = 3'h0;
   localparam logic [2:0] CKS_CASCADE = 3'h7;
   localparam logic [2:0] CLR_NONE = 3'h0;
   localparam logic [2:0] CLR_A = 3'h1;
   localparam logic [2:0] CLR_B = 3'h2;
   localparam logic [2:0] CLR_SYNC = 3'h3;
   localparam logic [2:0] CLR_C = 3'h5;
   localparam logic [2:0] CLR_D = 3'h6;
   // pin level control: general register A captures the falling edge
   localparam int CAPA_FALL_BIT = 0;

   // channel mode register: operating mode in the low nibble
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_PWM1 = 4'h2;
   localparam logic [3:0] MODE_PWM2 = 4'h3;
   localparam logic [7:0] MODE_VAL_PWM1 = 8'hc2;
   localparam logic [7:0] MODE_VAL_PWM2 = 8'hc3;

   // reset values
   localparam logic [5:0] START_RST = 6'h00;
   localparam logic [5:0] SYNC_RST = 6'h00;
   localparam logic [5:0] SYNC_ALL = 6'h3f;
   localparam logic STOP_RST = 1'b1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'hc0;
   localparam logic [7:0] PIN_RST = 8'h00;
   localparam logic [15:0] GR_RST = 16'hffff;
   localparam logic [15:0] COUNT_MAX = 16'hffff;

   // cascade pairing: upper half counts overflows of the lower half
   localparam int CASCADE_HI_CH = 1;
   localparam int CASCADE_LO_CH = 2;

   // timing: base tick emulates the 50 ns phase of a 20 MHz core clock
   localparam int SYS_CLK_MHZ = 200;
   localparam int PHI_PERIOD_NS = 50;
   localparam int PHI_CYCLES = (PHI_PERIOD_NS * SYS_CLK_MHZ) / 1000;
   localparam int MIN_DELAY_NS = 200;
   localparam int MIN_WIDTH_NS = 50;
   localparam int MIN_CYCLE_NS = 100;
   localparam int MIN_DELAY_TICKS = (MIN_DELAY_NS + PHI_PERIOD_NS - 1) / PHI_PERIOD_NS;
   localparam int MIN_WIDTH_TICKS = (MIN_WIDTH_NS + PHI_PERIOD_NS - 1) / PHI_PERIOD_NS;
   localparam logic [15:0] MIN_TRIGGER_TICKS = 16'(MIN_DELAY_TICKS + MIN_WIDTH_TICKS);

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: timer_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic enable,
   output logic [3:0] ticks
);
   logic [7:0] phiCount;
   logic [5:0] divCount;
   logic phiTick;

   // base phase divider
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         phiCount <= 8'h00;
      end else if (!enable || phiCount == 8'(timer_pkg::PHI_CYCLES - 1)) begin
         phiCount <= 8'h00;
      end else begin
         phiCount <= phiCount + 8'h01;
      end
   end

   assign phiTick = enable && (phiCount == 8'(timer_pkg::PHI_CYCLES - 1));

   // ratio divider counting base ticks
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         divCount <= 6'h00;
      end else if (phiTick) begin
         divCount <= divCount + 6'h01;
      end
   end

   // ratios 1, 4, 16, 64
   for (genvar k = 0; k < 4; k++) begin : g_ratio
      if (k == 0) begin : g_one
         assign ticks[k] = phiTick;
      end else begin : g_div
         assign ticks[k] = phiTick && (&divCount[2*k-1:0]);
      end
   end
endmodule
`default_nettype wire

// File: trigger_source.sv
`timescale 1ns/10ps
`default_nettype none
module trigger_source #(
   parameter int PERIOD = 400,
   parameter int LOW = 20
) (
   input wire logic clk_sys,
   input wire logic enable,
   output logic [5:0] pin
);
   int cnt = 0;
   initial pin = 6'h3f;
   // one falling edge on channel 1's pin per period, idle high otherwise
   always @(posedge clk_sys) begin
      cnt <= (!enable || cnt == PERIOD - 1) ? 0 : cnt + 1;
      pin <= {4'hf, !(enable && cnt < LOW), 1'b1};
   end
endmodule
`default_nettype wire
